/* File: rtl/mcr_device.sv */
// Purpose: converter end: clock ratios, forwarded clock, timing check
// Assumes: mclk stands for the sampling clock; settings are plain inputs
// Notes:   half-period shifted sampling is modelled by adjacent edges
//
// What this block, the source end and the system do
// R1: divide select 1 doubles forwarded clock period
// R2: divide select 0 gives fs over 2NM
// R3: field 00/01 ratio 1, 10 ratio 2, 11 ratio 4
// R4: under-clock ratio applies in both mux ratios
// R5: mux runs on clock divided by ratio
// R6: ratio 1 mux4 accepts words at fs/4
// R7: ratio 2 halves word and forwarded rate
// R8: delay trim 0..5, 14 ps steps, reset 2
// R9: source sets trim 4 at high rates
// R10: source toggles check lane every data cycle
// R11: unused check lane held static by source
// R12: check lane sampled by two shifted clocks
// R13: flag 1 when the two samples differ
// R14: on violation system shifts forwarded phase
// R15: phase shift delays forwarded clock half-steps
// R16: mux2 only first four phase settings distinct
// R17: flag refreshed every input data cycle
`timescale 1ns/1ps
`default_nettype none
module mcr_device #(
    parameter int DEPTH = mcr_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst_n,
    // configuration settings
    input  wire logic [1:0]                 underclock_ratio_field,
    input  wire logic                       mux_ratio_sel,
    input  wire logic                       forwarded_clock_divide_select,
    input  wire logic [2:0]                 forwarded_clock_phase_shift,
    input  wire logic [2:0]                 mux_sampling_delay_trim,
    // converter side words
    output logic [mcr_pkg::WORD_W-1:0]      conv_word,
    output logic                            conv_strobe,
    output logic [2:0]                      trim_applied,
    output logic [1:0]                      input_underclock_ratio,
    // status
    output logic                            timing_violation_flag,
    // link
    mcr_link_if.device                      link
);
    initial begin
        if (DEPTH < 2) $error("depth too small");
    end
    // settings registered so outputs and dividers see stable values
    logic [1:0] ucr_reg;
    logic       mux2_reg;
    logic       fdiv_reg;
    logic [2:0] phase_reg;
    logic [2:0] trim_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ucr_reg   <= mcr_pkg::UCR_RESET;
            mux2_reg  <= mcr_pkg::MUX4;
            fdiv_reg  <= mcr_pkg::FDIV_RESET;
            phase_reg <= mcr_pkg::PHASE_RESET;
            trim_reg  <= mcr_pkg::TRIM_RESET; // R8
        end else begin
            ucr_reg   <= underclock_ratio_field;
            mux2_reg  <= mux_ratio_sel;
            fdiv_reg  <= forwarded_clock_divide_select;
            phase_reg <= forwarded_clock_phase_shift;
            // out-of-range trim is clamped rather than wrapped
            trim_reg  <= (mux_sampling_delay_trim > mcr_pkg::TRIM_MAX) ?
                         mcr_pkg::TRIM_MAX : mux_sampling_delay_trim; // R8
        end
    end
    // log2 of under-clock ratio, used in both mux ratios
    logic [1:0] m_log;
    always_comb begin
        case (ucr_reg)
            mcr_pkg::UCR_X2: m_log = 2'h1; // R3
            mcr_pkg::UCR_X4: m_log = 2'h2; // R3
            default:         m_log = 2'h0; // R3
        endcase
    end
    // word period = N*M cycles; forwarded half period = N*M*X
    logic [3:0] word_log;
    logic [3:0] half_log;
    assign word_log = {2'h0, m_log} + (mux2_reg ? 4'h1 : 4'h2); // R4 R5 R6 R7
    assign half_log = word_log + {3'h0, fdiv_reg}; // R1 R2
    logic [mcr_pkg::DIV_W-1:0] cnt_reg;
    logic [mcr_pkg::DIV_W-1:0] word_mask;
    logic [mcr_pkg::DIV_W-1:0] half_mask;
    assign word_mask = mcr_pkg::DIV_W'((1 << word_log) - 1);
    assign half_mask = mcr_pkg::DIV_W'((1 << half_log) - 1);
    logic word_tick;
    logic half_tick;
    assign word_tick = (cnt_reg & word_mask) == word_mask; // R5
    assign half_tick = (cnt_reg & half_mask) == half_mask;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
    // base forwarded clock toggles every N*M*X cycles
    logic fwd_base_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_base_reg <= 1'b0;
        end else if (half_tick) begin
            fwd_base_reg <= ~fwd_base_reg; // R1 R2
        end
    end
    // phase delay line; one mclk stands for half an input cycle
    logic [7:0] dly_reg;
    logic [2:0] phase_eff;
    assign phase_eff = mux2_reg ? {1'b0, phase_reg[1:0]} : phase_reg; // R16
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dly_reg <= '0;
        end else begin
            dly_reg <= {dly_reg[6:0], fwd_base_reg}; // R15
        end
    end
    logic fwd_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fwd_reg <= 1'b0;
        end else begin
            fwd_reg <= dly_reg[phase_eff]; // R15
        end
    end
    assign link.fwd_clk = fwd_reg;
    // word request toward the source, one per word period
    logic strobe_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= word_tick; // R6 R7
        end
    end
    assign link.word_strobe = strobe_reg;
    // incoming words buffered; drained at the mux rate
    logic                       f_out_valid;
    logic [mcr_pkg::WORD_W-1:0] f_out_data;
    logic                       f_in_ready;
    mcr_fifo #(.W(mcr_pkg::WORD_W), .D(DEPTH)) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (strobe_reg && f_in_ready), // a full buffer refuses the word
        .in_ready  (f_in_ready),
        .in_data   (link.data),
        .out_valid (f_out_valid),
        .out_ready (word_tick),
        .out_data  (f_out_data)
    );
    // converter holds each word for N*M conversions
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_word   <= '0;
            conv_strobe <= 1'b0;
        end else begin
            conv_strobe <= word_tick && f_out_valid; // R5
            if (word_tick && f_out_valid) begin
                conv_word <= f_out_data;
            end
        end
    end
    // trim and ratio shown to the analog side
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trim_applied           <= mcr_pkg::TRIM_RESET;
            input_underclock_ratio <= 2'h0;
        end else begin
            trim_applied           <= trim_reg; // R8
            input_underclock_ratio <= m_log; // R3
        end
    end
    // early and late samples of the check lane around the word edge
    logic lane;
    logic early_reg;
    logic late_reg;
    assign lane = link.check_lane_pos & ~link.check_lane_neg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            early_reg <= 1'b0;
            late_reg  <= 1'b0;
        end else begin
            late_reg <= lane; // R12
            if (word_tick) begin
                early_reg <= lane; // R12
            end
        end
    end
    // compared once per word, one cycle after the early sample
    logic cmp_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_reg <= 1'b0;
        end else begin
            cmp_reg <= word_tick;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timing_violation_flag <= 1'b0;
        end else if (cmp_reg) begin
            timing_violation_flag <= early_reg ^ lane; // R13 R17
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mcr_pkg.sv */
// Purpose: shared constants for the mux clock ratio and timing check ends
// Assumes: one clock domain, mclk at 125 MHz
// Notes:   encodings of the under-clock field, trim and phase settings
package mcr_pkg;
    localparam logic [1:0] UCR_RESET      = 2'h0;
    localparam logic [1:0] UCR_X2         = 2'h2;
    localparam logic [1:0] UCR_X4         = 2'h3;
    localparam logic [2:0] TRIM_RESET     = 3'h2;
    localparam logic [2:0] TRIM_MAX       = 3'h5;
    localparam logic [2:0] TRIM_HIGH_RATE = 3'h4;
    localparam int         TRIM_STEP_PS   = 14;
    localparam logic [2:0] PHASE_RESET    = 3'h0;
    localparam logic       FDIV_RESET     = 1'b0;
    localparam logic       MUX4           = 1'b0;
    localparam int         WORD_W         = 12;
    localparam int         FIFO_DEPTH     = 8;
    localparam int         DIV_W          = 8;
endpackage

/* File: rtl/mcr_link_if.sv */
// Purpose: link between converter end and data source end
// Assumes: fwd_clk is a level sampled on mclk by the source
// Notes:   check lane is differential, carried as a pair of levels
`timescale 1ns/1ps
`default_nettype none
interface mcr_link_if;
    logic                        fwd_clk;
    logic [mcr_pkg::WORD_W-1:0]  data;
    logic                        check_lane_pos;
    logic                        check_lane_neg;
    logic                        word_strobe;
    modport device (output fwd_clk, output word_strobe, input data,
                    input check_lane_pos, input check_lane_neg);
    modport source (input fwd_clk, input word_strobe, output data,
                    output check_lane_pos, output check_lane_neg);
endinterface
`default_nettype wire

/* File: rtl/mcr_fifo.sv */
// Purpose: small word buffer with valid/ready on both sides
// Assumes: single clock
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module mcr_fifo #(
    parameter int W = 12,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("fifo depth must be power of two");
    end
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_reg;
    logic [AW:0]  rd_reg;
    logic         push;
    logic         pop;
    assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(D);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem[rd_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // storage has no reset, pointers do
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

/* File: rtl/mcr_source.sv */
// Purpose: data source end: feeds words and the check lane
// Assumes: word_strobe from the device paces transfers
// Notes:   stalls the user when no request is due
`timescale 1ns/1ps
`default_nettype none
module mcr_source (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    // user side
    input  wire logic [mcr_pkg::WORD_W-1:0]  user_word,
    input  wire logic                        user_valid,
    input  wire logic                        check_enable,
    output logic                             user_ready,
    // link
    mcr_link_if.source                       link
);
    logic [mcr_pkg::WORD_W-1:0] data_reg;
    logic                       lane_reg;
    logic                       lane_neg_reg;
    // word handed out on each strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_reg   <= '0;
            user_ready <= 1'b0;
        end else begin
            user_ready <= link.word_strobe;
            if (link.word_strobe && user_valid) begin
                data_reg <= user_word;
            end
        end
    end
    // toggles with each word, static when check unused
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lane_reg     <= 1'b0;
            lane_neg_reg <= 1'b1;
        end else if (check_enable && link.word_strobe) begin
            lane_reg     <= ~lane_reg; // R10
            lane_neg_reg <= lane_reg; // both halves of the pair from flops
        end
    end
    assign link.data           = data_reg;
    assign link.check_lane_pos = lane_reg; // R11
    assign link.check_lane_neg = lane_neg_reg;
endmodule
`default_nettype wire

/* File: test/mcr_checker.sv */
// Purpose: timing checks on the first link and device status
// Assumes: settings only change while rst_n is low
// Notes:   interval checks arm after the first event
`timescale 1ns/1ps
`default_nettype none
module mcr_checker (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // settings
    input wire logic [1:0]  underclock_ratio_field,
    input wire logic        mux_ratio_sel,
    input wire logic        forwarded_clock_divide_select,
    input wire logic [2:0]  mux_sampling_delay_trim,
    // watched signals
    input wire logic        fwd_clk,
    input wire logic        word_strobe,
    input wire logic        check_lane_pos,
    input wire logic [11:0] conv_word,
    input wire logic        conv_strobe,
    input wire logic [2:0]  trim_applied,
    input wire logic [1:0]  input_underclock_ratio,
    input wire logic        timing_violation_flag
);
    // log2 of the ratio, word interval, forwarded half period, clamped trim
    wire logic [1:0] sh   = underclock_ratio_field[1] ?
                            {underclock_ratio_field[0], ~underclock_ratio_field[0]} : 2'h0;
    wire logic [6:0] nm   = (mux_ratio_sel ? 7'h02 : 7'h04) << sh;
    wire logic [6:0] half = nm << forwarded_clock_divide_select;
    wire logic [2:0] tx   = (mux_sampling_delay_trim > mcr_pkg::TRIM_MAX) ?
                            mcr_pkg::TRIM_MAX : mux_sampling_delay_trim;
    logic [6:0] gap_reg;
    logic [6:0] fgap_reg;
    logic [3:0] still_reg;
    logic       seen_reg;
    logic       fseen_reg;
    // cycles since last event; the first event only arms the check
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg   <= 7'h01;
            fgap_reg  <= 7'h01;
            still_reg <= 4'h0;
            seen_reg  <= 1'b0;
            fseen_reg <= 1'b0;
        end else begin
            gap_reg   <= word_strobe ? 7'h01 : gap_reg + 7'h01;
            fgap_reg  <= $changed(fwd_clk) ? 7'h01 : fgap_reg + 7'h01;
            still_reg <= $changed(check_lane_pos) ? 4'h0 : still_reg + {3'h0, ~&still_reg};
            seen_reg  <= seen_reg | word_strobe;
            fseen_reg <= fseen_reg | $changed(fwd_clk);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    strobe_period_a: assert property (word_strobe && seen_reg |-> gap_reg == nm)
        else $error("word strobe interval wrong");
    strobe_due_a: assert property (seen_reg |-> gap_reg <= nm)
        else $error("word strobe overdue");
    fwd_half_a: assert property ($changed(fwd_clk) && fseen_reg |-> fgap_reg == half)
        else $error("forwarded clock half period wrong");
    fwd_due_a: assert property (fseen_reg |-> fgap_reg <= half)
        else $error("forwarded clock stalled");
    flag_moment_a: assert property ($changed(timing_violation_flag) |->
        word_strobe || $past(word_strobe)) else $error("flag moved off a word cycle");
    flag_static_a: assert property ($past(word_strobe, 2) && still_reg >= 4'h8 |->
        !timing_violation_flag) else $error("flag set on a static lane");
    conv_hold_a: assert property ($changed(conv_word) |-> conv_strobe)
        else $error("converter word moved without strobe");
    conv_gap_a: assert property (conv_strobe |=> !conv_strobe)
        else $error("converter strobes back to back");
    // two register stages between setting and shown value
    trim_clamp_a: assert property ($past(rst_n, 2) |-> trim_applied == tx)
        else $error("applied trim wrong");
    ratio_decode_a: assert property ($past(rst_n, 2) |-> input_underclock_ratio == sh)
        else $error("ratio decode wrong");
    cover property (word_strobe && seen_reg && mux_ratio_sel);
    cover property (fwd_clk && forwarded_clock_divide_select);
    cover property (conv_strobe);
endmodule
`default_nettype wire

/* File: test/mux_clock_ratio_timing_check_tb_top.sv */
// Purpose: self-checking run over all ratio settings and the lane check
// Assumes: settings change only while rst_n is low, except phase_b of the second device
// Notes:   second device gets a bench lane to force violations
`timescale 1ns/1ps
`default_nettype none
module mux_clock_ratio_timing_check_tb_top;
    mcr_link_if link_a ();
    mcr_link_if link_b ();
    // inputs
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  field = 2'h0;
    logic        mux = 1'b0;
    logic        fdiv = 1'b0;
    logic [2:0]  phase_b = 3'h0;
    logic [2:0]  trim = 3'h0;
    logic [11:0] user_word = 12'h001;
    logic        user_valid = 1'b0;
    logic        check_enable = 1'b0;
    logic        lane_b = 1'b0;
    // outputs and bench state
    logic [11:0] conv_word;
    logic [2:0]  trim_ap;
    logic [1:0]  ucr;
    logic        conv_strobe, flag_a, flag_b, user_ready;
    int          seed = 32'h4178;
    int          errors = 0, check_count = 0, n_strobe, n_tog, dly, n_conv, n_took;
    bit          win = 1'b0, started, took;
    logic [7:0]  hist_reg = 8'h00;
    logic [11:0] sent[$];
    wire logic [8:0] fwd_hist = {hist_reg, link_a.fwd_clk};
    mcr_device i_mcr_device (.mclk(mclk), .rst_n(rst_n), .underclock_ratio_field(field),
        .mux_ratio_sel(mux), .forwarded_clock_divide_select(fdiv),
        .forwarded_clock_phase_shift(3'h0), .mux_sampling_delay_trim(trim),
        .conv_word(conv_word), .conv_strobe(conv_strobe), .trim_applied(trim_ap),
        .input_underclock_ratio(ucr), .timing_violation_flag(flag_a), .link(link_a));
    mcr_device i_mcr_device_b (.mclk(mclk), .rst_n(rst_n), .underclock_ratio_field(field),
        .mux_ratio_sel(mux), .forwarded_clock_divide_select(fdiv),
        .forwarded_clock_phase_shift(phase_b), .mux_sampling_delay_trim(trim),
        .conv_word(), .conv_strobe(), .trim_applied(), .input_underclock_ratio(),
        .timing_violation_flag(flag_b), .link(link_b));
    mcr_source i_mcr_source (.mclk(mclk), .rst_n(rst_n), .user_word(user_word),
        .user_valid(user_valid), .check_enable(check_enable), .user_ready(user_ready),
        .link(link_a));
    mcr_checker i_mcr_checker (.mclk(mclk), .rst_n(rst_n), .underclock_ratio_field(field),
        .mux_ratio_sel(mux), .forwarded_clock_divide_select(fdiv),
        .mux_sampling_delay_trim(trim), .fwd_clk(link_a.fwd_clk),
        .word_strobe(link_a.word_strobe), .check_lane_pos(link_a.check_lane_pos),
        .conv_word(conv_word), .conv_strobe(conv_strobe), .trim_applied(trim_ap),
        .input_underclock_ratio(ucr), .timing_violation_flag(flag_a));
    // the second link carries a lane that breaks alignment on purpose
    assign link_b.data = 12'hA5A;
    assign link_b.check_lane_pos = lane_b;
    assign link_b.check_lane_neg = ~lane_b;
    always #4 mclk = ~mclk;
    function automatic int nm(input logic [3:0] c);
        return (c[0] ? 2 : 4) * (c[3] ? (c[2] ? 4 : 2) : 1);
    endfunction
    task automatic note(input bit bad);
        check_count++;
        if (bad) begin
            errors++;
            $display("wrong value at %0t: result differs", $time);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        note(got !== exp);
    endtask
    task automatic chk_word(input logic [11:0] got, input logic [11:0] exp);
        note(got !== exp);
    endtask
    task automatic chk_num(input int got, input int exp);
        note(got != exp);
    endtask
    // scoreboard, link watch and forwarded clock history
    always @(posedge mclk) begin
        took = rst_n && user_valid && user_ready;
        if (took) sent.push_back(user_word);
        if (rst_n && conv_strobe && (started || conv_word !== 12'h000)) begin
            started = 1'b1;
            if (sent.size() > 0) chk_word(conv_word, sent.pop_front());
        end
        if (rst_n) chk_bit(flag_a, 1'b0);
        if (win) begin
            n_strobe += int'(link_a.word_strobe);
            n_conv += int'(conv_strobe === 1'b1);
            n_took += int'(took);
            n_tog += int'(fwd_hist[0] != fwd_hist[1]);
            chk_bit(link_b.fwd_clk, fwd_hist[dly]);
            chk_bit(link_a.check_lane_neg, ~link_a.check_lane_pos);
        end
        hist_reg <= fwd_hist[7:0];
    end
    // new word only after the source took the last one
    always @(negedge mclk) begin
        if (took) user_word <= 12'($random(seed)) | 12'h001;
    end
    // buffer seen only from outside: one strobe, one source take and one converter word per period
    task automatic buffer_test();
        repeat (32) @(negedge mclk);
        n_strobe = 0;
        n_conv = 0;
        n_took = 0;
        win = 1'b1;
        repeat (64) @(negedge mclk);
        win = 1'b0;
        chk_num(n_strobe, 64 / nm(4'h0));
        chk_num(n_took, 64 / nm(4'h0));
        chk_num(n_conv, 64 / nm(4'h0));
        $display("test done: buffer");
    endtask
    task automatic run_cfg(input logic [3:0] c);
        @(negedge mclk);
        rst_n = 1'b0;
        mux = c[0];
        fdiv = c[1];
        field = c[3:2];
        trim = c[3] ? mcr_pkg::TRIM_HIGH_RATE : 3'($random(seed));
        phase_b = 3'($random(seed));
        dly = mux ? int'(phase_b[1:0]) : int'(phase_b);
        check_enable = 1'($random(seed));
        sent.delete();
        started = 1'b0;
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        repeat (96) @(negedge mclk);
        n_strobe = 0;
        n_tog = 0;
        win = 1'b1;
        repeat (192) @(negedge mclk);
        win = 1'b0;
        chk_num(n_strobe, 192 / nm(c));
        chk_num(n_tog, 192 / (nm(c) * (c[1] ? 2 : 1)));
        repeat (40) begin
            @(negedge mclk);
            lane_b = ~lane_b;
        end
        chk_bit(flag_b, 1'b1);
        // system answers the violation by moving the forwarded clock phase
        phase_b = phase_b + (mux ? 3'h2 : 3'h4);
        repeat (40) @(negedge mclk);
        chk_bit(flag_b, 1'b0);
        $display("test done: setting %0h", c);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        user_valid = 1'b1;
        buffer_test();
        for (int c = 0; c < 16; c++) run_cfg(4'(c));
        close_out();
    end
    // hang guard, well beyond the planned run
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        close_out();
    end
endmodule
`default_nettype wire
